// ### include/faru_pkg.sv
// Constants, register offsets and types for the fault alarm response unit.
// Assumes a single 40 MHz clock and a simple strobe register port.
// How it works
// RULE1: A voltage, frequency, temperature or light sensor alarm forces a chip reset.
// RULE2: The memory light detector or any fault-injection detector raises an exception.
// RULE3: Fault-injection inputs come from PC, SP, upper status word, cipher and arithmetic units.
// RULE4: On any reset all state of the unit returns to its defined reset value; a reset alarm clears only the exception status.
// RULE5: The source of the most recent reset is kept readable by software after restart.
// RULE6: Each raised exception leaves a readable indication of which detector caused it.
// RULE7: With inverse error correction enabled, a detected memory error raises an exception.
// RULE8: Outside factory test mode all sensors are enabled automatically.
// RULE9: Software writes cannot disable the sensors.
// RULE10: The reset or exception mapping of each alarm is fixed in hardware.
// RULE11: User, system and privileged modes each have their own stack limit check raising an exception.
// RULE12: The write high-voltage check only posts a readable flag, with no reset or exception.
// RULE13: Software selects at most one memory light detection function, and the unit honours it.
// RULE14: Memory read data with a single-bit error per byte is corrected automatically.
// RULE15: A program ROM parity error forces a chip reset.
// RULE16: The privileged mode group bit selects boot, test or contactless mode by hardware; the code takes these from boot_done and test_mode_fuse.
// RULE17: A reset alarm in the same cycle as an exception alarm wins and is recorded.
package faru_pkg;
	localparam int unsigned        ADDR_W          = 4;
	localparam logic [ADDR_W-1:0]  OFF_RST_CAUSE   = 4'h0;
	localparam logic [ADDR_W-1:0]  OFF_EXC_STATUS  = 4'h1;
	localparam logic [ADDR_W-1:0]  OFF_EXC_MASK    = 4'h2;
	localparam logic [ADDR_W-1:0]  OFF_CTRL        = 4'h3;
	localparam logic [ADDR_W-1:0]  OFF_SENSOR_EN   = 4'h4;
	localparam logic [ADDR_W-1:0]  OFF_HV_STATUS   = 4'h5;
	localparam logic [ADDR_W-1:0]  OFF_MODE        = 4'h6;
	// Reset cause bits
	localparam int unsigned        RC_W            = 6;
	localparam int unsigned        RC_VOLT         = 0;
	localparam int unsigned        RC_FREQ         = 1;
	localparam int unsigned        RC_TEMP         = 2;
	localparam int unsigned        RC_LIGHT        = 3;
	localparam int unsigned        RC_PARITY       = 4;
	localparam int unsigned        RC_POWERON      = 5;
	localparam logic [RC_W-1:0]    RC_RESET_VAL    = 6'h20;
	// Exception status bits
	localparam int unsigned        EX_W            = 11;
	localparam int unsigned        EX_MEM_LIGHT    = 0;
	localparam int unsigned        EX_FI_PC        = 1;
	localparam int unsigned        EX_FI_SP        = 2;
	localparam int unsigned        EX_FI_PSW       = 3;
	localparam int unsigned        EX_FI_CIPH      = 4;
	localparam int unsigned        EX_FI_ARITH     = 5;
	localparam int unsigned        EX_ECC          = 6;
	localparam int unsigned        EX_STK_USER     = 7;
	localparam int unsigned        EX_STK_SYS      = 8;
	localparam int unsigned        EX_STK_PRIV     = 9;
	localparam int unsigned        EX_ECC_CORR     = 10;
	localparam logic [EX_W-1:0]    EX_MASK_RESET   = 11'h7FF;
	// Control bits
	localparam int unsigned        CTRL_W          = 3;
	localparam int unsigned        CTRL_LD_SEL0    = 0;
	localparam int unsigned        CTRL_LD_SEL1    = 1;
	localparam int unsigned        CTRL_INV_ECC    = 2;
	localparam logic [CTRL_W-1:0]  CTRL_RESET_VAL  = 3'h0;
	localparam int unsigned        SENS_W          = 4;
	localparam logic [SENS_W-1:0]  SENS_ALL_ON     = 4'hF;
	// Chip reset pulse length
	localparam int unsigned        CLK_MHZ         = 40;
	localparam int unsigned        RST_PULSE_NS    = 100;
	localparam int unsigned        RST_PULSE_CYC   =
		(RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned        CNT_W           = 3;
	typedef enum logic [1:0] {
		FARU_MODE_USER,
		FARU_MODE_SYS,
		FARU_MODE_PRIV
	} faru_mode_t;
	typedef enum logic [1:0] {
		FARU_PRIV_BOOT,
		FARU_PRIV_TEST,
		FARU_PRIV_CLESS
	} faru_priv_t;
endpackage : faru_pkg

// ### verilog/faru_top.sv
// Fault alarm response unit: alarm collection, reset and exception issue.
// Assumes alarm pins are asynchronous and the register master never waits.
`timescale 1ns/10ps
module faru_top
	import faru_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [3:0]        sensor_alarm,
	input  wire logic              mem_light_alarm_a,
	input  wire logic              mem_light_alarm_b,
	input  wire logic [4:0]        fault_inj,
	input  wire logic              rom_parity_err,
	input  wire logic              test_mode_fuse,
	input  wire logic              mode_user,
	input  wire logic              privileged_mode_group_bit,
	input  wire logic              boot_done,
	input  wire logic [7:0]        stack_ptr,
	input  wire logic [7:0]        stack_lim_user,
	input  wire logic [7:0]        stack_lim_sys,
	input  wire logic [7:0]        stack_lim_priv,
	input  wire logic              mem_rd_valid,
	input  wire logic [7:0]        mem_rd_data,
	input  wire logic [3:0]        mem_rd_chk,
	input  wire logic              hv_check_strobe,
	input  wire logic              hv_ok,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	output logic                   chip_reset,
	output logic                   exc_req,
	output logic                   irq,
	output logic [SENS_W-1:0]      sensor_en,
	output logic [7:0]             mem_corr_data,
	output logic                   mem_corr_valid
);
	localparam int unsigned NA = 4 + 2 + 5 + 1;
	logic [NA-1:0] raw_in;
	logic [NA-1:0] s1_q, s2_q, s3_q;
	logic [NA-1:0] al_q;
	assign raw_in = {rom_parity_err, fault_inj, mem_light_alarm_b,
		mem_light_alarm_a, sensor_alarm};

	// Three-stage synchroniser; a change counts when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NA; gi++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					al_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= raw_in[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) al_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate

	logic [CTRL_W-1:0] ctrl_q;
	logic [EX_W-1:0]   exc_stat_q, exc_mask_q, exc_ev;
	logic [RC_W-1:0]   rc_q, rc_ev;
	logic              hv_fail_q, hv_done_q;
	logic [CNT_W-1:0]  rst_cnt_q;
	logic              test_mode_q;
	faru_mode_t        mode;
	faru_priv_t        priv_q;
	logic              ld_sel;

	// Fixed alarm-to-response wiring, no software path alters it
	assign rc_ev[RC_VOLT]    = al_q[0] & sensor_en[0]; // RULE1 RULE10
	assign rc_ev[RC_FREQ]    = al_q[1] & sensor_en[1]; // RULE1 RULE10
	assign rc_ev[RC_TEMP]    = al_q[2] & sensor_en[2]; // RULE1 RULE10
	assign rc_ev[RC_LIGHT]   = al_q[3] & sensor_en[3]; // RULE1 RULE10
	assign rc_ev[RC_PARITY]  = al_q[11]; // RULE15
	assign rc_ev[RC_POWERON] = 1'b0;

	// Only one memory light detector is honoured; both bits set selects none
	assign ld_sel = (ctrl_q[CTRL_LD_SEL0] & ~ctrl_q[CTRL_LD_SEL1] & al_q[4])
		| (ctrl_q[CTRL_LD_SEL1] & ~ctrl_q[CTRL_LD_SEL0] & al_q[5]); // RULE13

	always_comb begin
		mode = FARU_MODE_SYS;
		if (privileged_mode_group_bit) mode = FARU_MODE_PRIV;
		else if (mode_user) mode = FARU_MODE_USER;
	end

	// Single-error correction per byte with a Hamming(12,8) check nibble
	logic [3:0] syn;
	logic [7:0] d;
	logic [7:0] fix;
	assign d = mem_rd_data;
	assign syn[0] = mem_rd_chk[0] ^ d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
	assign syn[1] = mem_rd_chk[1] ^ d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
	assign syn[2] = mem_rd_chk[2] ^ d[1] ^ d[2] ^ d[3] ^ d[7];
	assign syn[3] = mem_rd_chk[3] ^ d[4] ^ d[5] ^ d[6] ^ d[7];
	always_comb begin
		fix = 8'h00;
		case (syn)
			4'h3: fix = 8'h01;
			4'h5: fix = 8'h02;
			4'h6: fix = 8'h04;
			4'h7: fix = 8'h08;
			4'h9: fix = 8'h10;
			4'hA: fix = 8'h20;
			4'hB: fix = 8'h40;
			4'hC: fix = 8'h80;
			default: fix = 8'h00;
		endcase
	end

	always_comb begin
		exc_ev = '0;
		exc_ev[EX_MEM_LIGHT] = ld_sel; // RULE2
		exc_ev[EX_FI_PC]     = al_q[6]; // RULE2 RULE3
		exc_ev[EX_FI_SP]     = al_q[7]; // RULE3
		exc_ev[EX_FI_PSW]    = al_q[8]; // RULE3
		exc_ev[EX_FI_CIPH]   = al_q[9]; // RULE3
		exc_ev[EX_FI_ARITH]  = al_q[10]; // RULE3
		exc_ev[EX_ECC] = ctrl_q[CTRL_INV_ECC] & mem_rd_valid
			& (syn != 4'h0); // RULE7
		exc_ev[EX_ECC_CORR] = 1'b0;
		exc_ev[EX_STK_USER] = (mode == FARU_MODE_USER)
			& (stack_ptr >= stack_lim_user); // RULE11
		exc_ev[EX_STK_SYS] = (mode == FARU_MODE_SYS)
			& (stack_ptr >= stack_lim_sys); // RULE11
		exc_ev[EX_STK_PRIV] = (mode == FARU_MODE_PRIV)
			& (stack_ptr >= stack_lim_priv); // RULE11
	end

	// Corrected read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_corr_data  <= 8'h00;
			mem_corr_valid <= 1'b0;
		end else begin
			mem_corr_data  <= mem_rd_data ^ fix; // RULE14
			mem_corr_valid <= mem_rd_valid;
		end
	end

	// Test fuse is caught when boot_done ends boot; test mode then holds until reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			test_mode_q <= 1'b0;
			priv_q      <= FARU_PRIV_BOOT;
		end else begin
			case (priv_q)
				FARU_PRIV_BOOT: begin
					if (boot_done) begin
						priv_q <= test_mode_fuse ? FARU_PRIV_TEST
							: FARU_PRIV_CLESS; // RULE16
						test_mode_q <= test_mode_fuse;
					end
				end
				default: priv_q <= priv_q;
			endcase
		end
	end

	// Sensors on in all modes but test; software has no write path
	always_ff @(posedge clk or posedge rst) begin
		if (rst) sensor_en <= SENS_ALL_ON;
		else sensor_en <= test_mode_q ? '0 : SENS_ALL_ON; // RULE8 RULE9
	end

	// Chip reset pulse; reset beats exceptions in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_cnt_q  <= '0;
			chip_reset <= 1'b0;
		end else if (|rc_ev) begin
			rst_cnt_q  <= CNT_W'(RST_PULSE_CYC); // RULE1
			chip_reset <= 1'b1;
		end else if (rst_cnt_q != '0) begin
			rst_cnt_q  <= rst_cnt_q - 1'b1;
			chip_reset <= (rst_cnt_q != CNT_W'(1));
		end else begin
			chip_reset <= 1'b0;
		end
	end

	// Reset cause survives the chip reset pulse this unit issues
	always_ff @(posedge clk or posedge rst) begin
		if (rst) rc_q <= RC_RESET_VAL;
		else if (|rc_ev) rc_q <= rc_ev; // RULE5 RULE17
		else if (reg_rd && reg_addr == OFF_RST_CAUSE) rc_q <= '0;
	end

	// Exception status: set wins over read-clear; cleared in each cycle with a reset alarm
	always_ff @(posedge clk or posedge rst) begin
		if (rst) exc_stat_q <= '0; // RULE4
		else if (|rc_ev) exc_stat_q <= '0; // RULE17 RULE4
		else if (reg_rd && reg_addr == OFF_EXC_STATUS) exc_stat_q <= exc_ev;
		else exc_stat_q <= exc_stat_q | exc_ev; // RULE6
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			exc_req <= 1'b0;
			irq     <= 1'b0;
		end else begin
			exc_req <= ~(|rc_ev) & (|exc_ev); // RULE2 RULE17
			irq     <= |(exc_stat_q & ~exc_mask_q);
		end
	end

	// High-voltage write check only posts a flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hv_fail_q <= 1'b0;
			hv_done_q <= 1'b0;
		end else if (hv_check_strobe) begin
			hv_fail_q <= ~hv_ok; // RULE12
			hv_done_q <= 1'b1;
		end
	end

	// Register writes; the sensor enable word is read-only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q     <= CTRL_RESET_VAL;
			exc_mask_q <= EX_MASK_RESET;
		end else if (reg_wr) begin
			if (reg_addr == OFF_CTRL) ctrl_q <= reg_wdata[CTRL_W-1:0];
			else if (reg_addr == OFF_EXC_MASK)
				exc_mask_q <= reg_wdata[EX_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) reg_rdata <= 32'h0000_0000;
		else if (!reg_rd) reg_rdata <= 32'h0000_0000;
		else if (reg_addr == OFF_RST_CAUSE) reg_rdata <= 32'(rc_q);
		else if (reg_addr == OFF_EXC_STATUS) reg_rdata <= 32'(exc_stat_q);
		else if (reg_addr == OFF_EXC_MASK) reg_rdata <= 32'(exc_mask_q);
		else if (reg_addr == OFF_CTRL) reg_rdata <= 32'(ctrl_q);
		else if (reg_addr == OFF_SENSOR_EN) reg_rdata <= 32'(sensor_en);
		else if (reg_addr == OFF_HV_STATUS)
			reg_rdata <= {30'h0, hv_done_q, hv_fail_q};
		else if (reg_addr == OFF_MODE)
			reg_rdata <= {28'h0, priv_q, mode};
		else reg_rdata <= 32'h0000_0000;
	end

	// Reset pulse stands the full count after the last reset alarm
	sequence s_rst_pulse;
		chip_reset [*4];
	endsequence
	sequence s_alarm_gone;
		(|rc_ev) ##1 (!(|rc_ev)) [*4];
	endsequence

	a_sensor_reset: assert property (@(posedge clk) // RULE1
		disable iff (rst) (|al_q[3:0]) && !test_mode_q |=> chip_reset)
		else $error("Sensor alarm did not force reset");
	a_pulse_len: assert property (@(posedge clk) // RULE1
		disable iff (rst) (|rc_ev) |=> s_rst_pulse)
		else $error("Chip reset pulse too short");
	a_pulse_end: assert property (@(posedge clk) // RULE1
		disable iff (rst) s_alarm_gone |=> !chip_reset)
		else $error("Chip reset pulse too long");
	a_exc_raise: assert property (@(posedge clk) // RULE2
		disable iff (rst) al_q[6] && !(|rc_ev) |=> exc_req)
		else $error("Fault detector did not raise exception");
	a_rst_wins: assert property (@(posedge clk) // RULE17
		disable iff (rst) (|rc_ev) |=> !exc_req && chip_reset)
		else $error("Exception not suppressed by reset");
	a_cause_kept: assert property (@(posedge clk) // RULE5
		disable iff (rst) rc_ev[RC_PARITY] |=> rc_q[RC_PARITY])
		else $error("Reset cause not recorded");
	a_cause_clear: assert property (@(posedge clk) // RULE5
		disable iff (rst) reg_rd && (reg_addr == OFF_RST_CAUSE)
		&& !(|rc_ev) |=> rc_q == '0)
		else $error("Reset cause not cleared by read");
	a_exc_status: assert property (@(posedge clk) // RULE6
		disable iff (rst) exc_ev[EX_FI_SP] && !(|rc_ev)
		|=> exc_stat_q[EX_FI_SP])
		else $error("Exception reason missing");
	a_stat_read: assert property (@(posedge clk) // RULE6
		disable iff (rst) reg_rd && (reg_addr == OFF_EXC_STATUS)
		|=> reg_rdata == 32'($past(exc_stat_q)))
		else $error("Exception reason not readable");
	a_sens_on: assert property (@(posedge clk) // RULE8
		disable iff (rst) !test_mode_q |=> sensor_en == SENS_ALL_ON)
		else $error("Sensors not enabled");
	a_hv_quiet: assert property (@(posedge clk) // RULE12
		disable iff (rst) hv_check_strobe && !hv_ok && !(|rc_ev)
		&& (rst_cnt_q == '0) |=> hv_fail_q && hv_done_q && !chip_reset)
		else $error("High voltage check not posted");
	a_parity_rst: assert property (@(posedge clk) // RULE15
		disable iff (rst) al_q[11] |=> chip_reset ##1 chip_reset)
		else $error("Parity error did not hold reset");
	a_ecc_exc: assert property (@(posedge clk) // RULE7
		disable iff (rst) ctrl_q[CTRL_INV_ECC] && mem_rd_valid
		&& (syn != 4'h0) && !(|rc_ev) |=> exc_req && exc_stat_q[EX_ECC])
		else $error("Memory error did not raise exception");
	a_ecc_fix: assert property (@(posedge clk) // RULE14
		disable iff (rst) mem_rd_valid |=> mem_corr_valid
		&& (mem_corr_data == ($past(mem_rd_data) ^ $past(fix))))
		else $error("Memory read not corrected");
endmodule : faru_top

// ### tb/faru_cpu_model.sv
// Processor core model: watches the chip reset and exception requests.
// Assumes the unit drives both outputs from registers on the rising edge.
`timescale 1ns/10ps
module faru_cpu_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic chip_reset,
	input  wire logic exc_req,
	output logic [7:0] rst_len_q,
	output logic [7:0] exc_cnt_q
);
	logic [7:0] run_q;
	// Core is held while chip reset is high; keep the held length
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_q     <= 8'h00;
			rst_len_q <= 8'h00;
		end else if (chip_reset) begin
			run_q <= run_q + 8'h01;
		end else begin
			if (run_q != 8'h00) rst_len_q <= run_q;
			run_q <= 8'h00;
		end
	end
	// Cycles in which the core was asked to take an exception
	always_ff @(posedge clk or posedge rst) begin
		if (rst) exc_cnt_q <= 8'h00;
		else exc_cnt_q <= exc_cnt_q + {7'h00, exc_req};
	end
endmodule : faru_cpu_model

// ### tb/faru_top_test.sv
// Self-checking bench for the fault alarm response unit.
// Assumes faru_cpu_model as the core; memory read path is driven only in t_mem.
`timescale 1ns/10ps
module faru_top_test
	import faru_pkg::*;
;
	logic clk, rst, mem_light_alarm_a, mem_light_alarm_b, rom_parity_err;
	logic test_mode_fuse, mode_user, boot_done, mem_rd_valid, hv_ok;
	logic privileged_mode_group_bit, hv_check_strobe, reg_wr, reg_rd;
	logic chip_reset, exc_req, irq, mem_corr_valid;
	logic [3:0] sensor_alarm, mem_rd_chk;
	logic [4:0] fault_inj;
	logic [7:0] stack_ptr, stack_lim_user, stack_lim_sys, stack_lim_priv;
	logic [7:0] mem_rd_data, mem_corr_data, rst_len, exc_cnt, e0;
	logic [ADDR_W-1:0] reg_addr;
	logic [SENS_W-1:0] sensor_en;
	logic [31:0] reg_wdata, reg_rdata, d;
	int n_mismatch, comparisons;

	faru_top faru_top_i (.clk, .rst, .sensor_alarm, .mem_light_alarm_a,
		.mem_light_alarm_b, .fault_inj, .rom_parity_err, .test_mode_fuse,
		.mode_user, .privileged_mode_group_bit, .boot_done, .stack_ptr,
		.stack_lim_user, .stack_lim_sys, .stack_lim_priv, .mem_rd_valid,
		.mem_rd_data, .mem_rd_chk, .hv_check_strobe, .hv_ok, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chip_reset, .exc_req,
		.irq, .sensor_en, .mem_corr_data, .mem_corr_valid);
	faru_cpu_model faru_cpu_model_i (.clk, .rst, .chip_reset, .exc_req,
		.rst_len_q(rst_len), .exc_cnt_q(exc_cnt));

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd
	task automatic wait_hi(input int sel);
		int k;
		k = 0;
		while ((sel ? chip_reset : exc_req) !== 1'b1 && k < 12) begin
			@(posedge clk);
			#1;
			k++;
		end
		check(sel ? "chip_reset" : "exc_req", 32'h1, 32'h1 & k < 12);
		while (sel && chip_reset === 1'b1 && k < 30) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (sel) begin
			tick(1);
			#1;
			// Alarms stand two cycles, so the pulse runs one past the count
			check("rst_len", 32'(RST_PULSE_CYC + 1), {24'h0, rst_len});
		end
	endtask : wait_hi
	task automatic t_regs;
		rd(OFF_RST_CAUSE, d);
		check("cause_por", {26'h0, RC_RESET_VAL}, d);
		rd(OFF_EXC_MASK, d);
		check("mask", {21'h0, EX_MASK_RESET}, d);
		wr(OFF_SENSOR_EN, 32'h0);
		rd(OFF_SENSOR_EN, d);
		check("sens_reg", {28'h0, SENS_ALL_ON}, d);
		check("sensor_en", {28'h0, SENS_ALL_ON}, {28'h0, sensor_en});
		rd(OFF_MODE, d);
		check("mode", 32'h9, d);
		rd(4'hF, d);
		check("unmapped", 32'h0, d);
		$display("test regs done");
	endtask : t_regs
	task automatic t_exc;
		wr(OFF_CTRL, 32'h1);
		wr(OFF_EXC_MASK, 32'h7FF);
		for (int j = -1; j < 6; j++) begin
			if (j == 0) wr(OFF_EXC_MASK, 32'h0);
			@(posedge clk);
			if (j == 0) mem_light_alarm_a <= 1'b1;
			else fault_inj <= 5'(1 << (j < 0 ? 0 : j - 1));
			wait_hi(0);
			@(posedge clk);
			mem_light_alarm_a <= 1'b0;
			fault_inj <= 5'h00;
			tick(3);
			#1;
			check("irq", {31'h0, j >= 0}, {31'h0, irq});
			check("no_reset", 32'h0, {31'h0, chip_reset});
			rd(OFF_EXC_STATUS, d);
			check("exc_status", 32'h1 << (j < 0 ? 1 : j), d);
		end
		@(posedge clk);
		mem_light_alarm_b <= 1'b1;
		tick(8);
		mem_light_alarm_b <= 1'b0;
		rd(OFF_EXC_STATUS, d);
		check("light_b_off", 32'h0, d);
		$display("test exc done");
	endtask : t_exc
	task automatic t_stack;
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			mode_user <= (m == 0);
			privileged_mode_group_bit <= (m == 2);
			stack_lim_user <= (m == 0) ? 8'h40 : 8'hFF;
			stack_lim_sys <= (m == 1) ? 8'h40 : 8'hFF;
			stack_lim_priv <= (m == 2) ? 8'h40 : 8'hFF;
			stack_ptr <= 8'h3F;
			tick(6);
			rd(OFF_EXC_STATUS, d);
			check("stk_below", 32'h0, d);
			@(posedge clk);
			stack_ptr <= 8'h40;
			wait_hi(0);
			@(posedge clk);
			stack_ptr <= 8'h00;
			tick(2);
			rd(OFF_EXC_STATUS, d);
			check("stk_status", 32'h1 << (EX_STK_USER + m), d);
		end
		$display("test stack done");
	endtask : t_stack
	task automatic t_mem;
		for (int p = 0; p < 2; p++) begin
			// Both light selects, then none: the light alarm is ignored
			wr(OFF_CTRL, p ? 32'h4 : 32'h3);
			@(posedge clk);
			mem_light_alarm_a <= 1'b1;
			mem_rd_valid <= 1'b1;
			mem_rd_data <= 8'hB5;
			mem_rd_chk <= 4'h3;
			@(posedge clk);
			mem_rd_valid <= 1'b0;
			#1;
			check("corr_data", 32'hA5, {24'h0, mem_corr_data});
			check("corr_valid", 32'h1, {31'h0, mem_corr_valid});
			tick(6);
			mem_light_alarm_a <= 1'b0;
			rd(OFF_EXC_STATUS, d);
			check("ecc_status", p ? 32'h40 : 32'h0, d);
		end
		$display("test mem done");
	endtask : t_mem
	task automatic t_hv;
		e0 = exc_cnt;
		@(posedge clk);
		hv_ok <= 1'b0;
		hv_check_strobe <= 1'b1;
		@(posedge clk);
		hv_check_strobe <= 1'b0;
		tick(8);
		rd(OFF_HV_STATUS, d);
		check("hv_status", 32'h3, d);
		check("hv_no_exc", {24'h0, e0}, {24'h0, exc_cnt});
		check("hv_no_rst", 32'h0, {31'h0, chip_reset});
		hv_ok <= 1'b1;
		$display("test hv done");
	endtask : t_hv
	task automatic t_resets;
		for (int i = 0; i < 6; i++) begin
			e0 = exc_cnt;
			@(posedge clk);
			if (i < 4) sensor_alarm <= 4'(1 << i);
			else rom_parity_err <= (i == 4);
			fault_inj <= (i == 5) ? 5'h01 : 5'h00;
			sensor_alarm[0] <= (i == 0) || (i == 5);
			// Two cycles so the pin filter counts the alarm
			tick(2);
			sensor_alarm <= 4'h0;
			rom_parity_err <= 1'b0;
			fault_inj <= 5'h00;
			wait_hi(1);
			rd(OFF_RST_CAUSE, d);
			check("rst_cause", 32'h1 << (i % 5), d);
			rd(OFF_EXC_STATUS, d);
			check("rst_status", 32'h0, d);
			check("rst_no_exc", {24'h0, e0}, {24'h0, exc_cnt});
		end
		$display("test resets done");
	endtask : t_resets

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		$display("Error watchdog expected finish seen hang");
		stop_test();
	end
	initial begin
		{rst, mem_light_alarm_a, mem_light_alarm_b, rom_parity_err} = 4'h8;
		{test_mode_fuse, mode_user, boot_done, mem_rd_valid, hv_ok} = 5'h01;
		{privileged_mode_group_bit, hv_check_strobe, reg_wr, reg_rd} = 4'h0;
		{sensor_alarm, mem_rd_chk, fault_inj, mem_rd_data} = 21'h0;
		{stack_lim_user, stack_lim_sys, stack_lim_priv} = 24'hFFFFFF;
		{stack_ptr, reg_addr, reg_wdata} = 44'h0;
		n_mismatch = 0;
		comparisons = 0;
		tick(6);
		rst <= 1'b0;
		@(posedge clk);
		boot_done <= 1'b1;
		t_regs();
		t_exc();
		t_stack();
		t_mem();
		t_hv();
		t_resets();
		stop_test();
	end
endmodule : faru_top_test
